// ---- bench/pco_act_model.sv ----
// actuator travel model with end-of-travel checkback contacts
module pco_act_model #(
	parameter int TRAVEL = 200
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// motor commands
	input  wire logic raise_i,
	input  wire logic lower_i,
	// checkback contacts
	output logic      upper_chk_o,
	output logic      lower_chk_o
);
	timeunit 1ns;
	timeprecision 1ps;

	int pos;

	// one step of travel per cycle while a single command is active
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos <= TRAVEL / 2;
		end else if (raise_i && !lower_i && pos < TRAVEL) begin
			pos <= pos + 1;
		end else if (lower_i && !raise_i && pos > 0) begin
			pos <= pos - 1;
		end
	end

	// contacts close only at the travel ends
	assign upper_chk_o = (pos >= TRAVEL);
	assign lower_chk_o = (pos <= 0);
endmodule

// ---- bench/tb.sv ----
// self-checking bench of the control output stage
`include "pco_regs.svh"
`define CHK(got, exp) begin samples_checked++; \
	if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); \
	end end

module tb
	import pco_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk             = 1'b0;
	logic        rst_n           = 1'b0;
	logic        psel            = 1'b0;
	logic        penable         = 1'b0;
	logic        pwrite          = 1'b0;
	logic [7:0]  paddr           = 8'h00;
	logic [31:0] pwdata          = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	pco_val_t    dev             = 16'sh0000;
	pco_val_t    track           = 16'sh0000;
	pco_val_t    ain             = 16'sh0000;
	logic        track_di        = 1'b0;
	logic        safe_di         = 1'b0;
	logic        up_chk;
	logic        lo_chk;
	pco_val_t    limited_manipulated_value;
	pco_val_t    aout;
	pco_pins_t   pins;
	logic        sample;
	logic [31:0] r;
	logic        e;
	int          n;
	int          mismatches      = 0;
	int          samples_checked = 0;

	always #5 clk = ~clk;

	pco_core #(.SAMPLE_RST(20)) uut (
		.core_clk_i(clk), .rst_n_i(rst_n),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.control_deviation_i(dev), .tracking_i(track), .analog_in_i(ain),
		.track_di_i(track_di), .safety_di_i(safe_di),
		.upper_chk_i(up_chk), .lower_chk_i(lo_chk),
		.limited_manipulated_value_o(limited_manipulated_value), .analog_out_o(aout),
		.pins_o(pins), .sample_o(sample)
	);

	pco_act_model #(.TRAVEL(200)) act (
		.clk_i(clk), .rst_n_i(rst_n),
		.raise_i(pins.raise), .lower_i(pins.lower),
		.upper_chk_o(up_chk), .lower_chk_o(lo_chk)
	);

	// ----------------------------------------------------------------
	// bus, timing and judging helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic stuck();
		mismatches++;
		$display("unexpected at %0t: got %h expected %h", $time, 0, 1);
		tally_and_finish();
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) stuck();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic wait_tick();
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (sample !== 1'b1 && n < 200);
		if (n >= 200) stuck();
	endtask

	// two ticks so a mid-period change has surely been sampled
	task automatic settle();
		wait_tick();
		wait_tick();
		@(posedge clk);
		#1;
	endtask

	task automatic setc(pco_ao_t ao, pco_mode_t m, logic [5:0] f);
		wr(`PCO_CTRL, {22'h0, ao, m, f});
	endtask

	task automatic law(pco_val_t d, pco_val_t x);
		@(posedge clk);
		dev <= d;
		settle();
		`CHK(limited_manipulated_value, x)
	endtask

	task automatic man(pco_val_t v, pco_val_t x);
		wr(`PCO_MANUAL, {16'h0, v});
		settle();
		`CHK(limited_manipulated_value, x)
	endtask

	task automatic pulses(output int a, output int b);
		a = 0;
		b = 0;
		repeat (250) @(posedge clk);
		repeat (100) begin
			@(posedge clk);
			#1;
			a += int'(pins.pulse_a);
			b += int'(pins.pulse_b);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, `PCO_LIMITS, 32'h0);
		`CHK(r, 32'h27100000)
		wr(8'h80, 32'h12345678);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h80, 32'h0);
		`CHK(r, 32'h00000000)
		apb(1'b0, `PCO_SPLIT_A_IN, 32'h0);
		`CHK(r, 32'h27100000)
		wr(`PCO_SAMPLE, 32'h14);
		wr(`PCO_PULSE, 32'h64);
	endtask

	task automatic t_period();
		wait_tick();
		wait_tick();
		`CHK(n, 32'h14)
		wr(`PCO_SAMPLE, 32'h1e);
		wait_tick();
		wait_tick();
		`CHK(n, 32'h1e)
		wr(`PCO_SAMPLE, 32'h14);
	endtask

	task automatic t_law();
		setc(PCO_AO_A, PCO_ANALOG, 6'b000011);
		wr(`PCO_KI, 32'h0);
		wr(`PCO_KD, 32'h0);
		wr(`PCO_OP_POINT, 32'h0);
		wr(`PCO_DEADBAND, 32'h0);
		wr(`PCO_GAIN, 32'h100);
		law(16'sh0000, 16'sh0000);
		law(16'sh09c4, 16'sh09c4);
		wr(`PCO_GAIN, 32'hff00);
		law(16'shf63c, 16'sh09c4);
		wr(`PCO_GAIN, 32'h100);
		// negative lower limit so the lower band branch shows its offset
		wr(`PCO_LIMITS, 32'h2710d8f0);
		wr(`PCO_DEADBAND, 32'h1f4);
		law(16'sh09c4, 16'sh07d0);
		law(16'shf63c, 16'shf830);
		law(16'sh0190, 16'sh0000);
		wr(`PCO_DEADBAND, 32'h0);
		wr(`PCO_LIMITS, 32'h27100000);
		wr(`PCO_OP_POINT, 32'h1f4);
		law(16'sh0000, 16'sh01f4);
	endtask

	task automatic t_auto_op();
		setc(PCO_AO_A, PCO_ANALOG, 6'b000110);
		man(16'sh0bb8, 16'sh0bb8);
		setc(PCO_AO_A, PCO_ANALOG, 6'b000111);
		law(16'sh0000, 16'sh0bb8);
		law(16'sh03e8, 16'sh0fa0);
		law(16'sh0000, 16'sh0bb8);
	endtask

	task automatic t_select();
		setc(PCO_AO_A, PCO_ANALOG, 6'b000010);
		wr(`PCO_LIMITS, 32'h1f4003e8);
		man(16'sh2328, 16'sh1f40);
		man(16'sh01f4, 16'sh03e8);
		wr(`PCO_SAFETY, 32'h1b58);
		@(posedge clk);
		track <= 16'sh07d0;
		track_di <= 1'b1;
		man(16'sh0bb8, 16'sh07d0);
		@(posedge clk);
		safe_di <= 1'b1;
		law(16'sh0000, 16'sh1b58);
		@(posedge clk);
		track_di <= 1'b0;
		safe_di <= 1'b0;
		law(16'sh0000, 16'sh0bb8);
		setc(PCO_AO_A, PCO_ANALOG, 6'b010010);
		law(16'sh0000, 16'sh07d0);
		wr(`PCO_LIMITS, 32'h27100000);
	endtask

	task automatic t_split();
		setc(PCO_AO_B, PCO_ANALOG, 6'b000010);
		wr(`PCO_SPLIT_B_OUT, 32'h00002710);
		man(16'sh09c4, 16'sh09c4);
		`CHK(aout, 16'sh1d4c)
		apb(1'b0, `PCO_OUTS, 32'h0);
		`CHK(r, 32'h1d4c09c4)
		ain <= 16'sh04d2;
		setc(PCO_AO_IN, PCO_ANALOG, 6'b000010);
		law(16'sh0000, 16'sh09c4);
		`CHK(aout, 16'sh04d2)
		setc(PCO_AO_A, PCO_ANALOG, 6'b000010);
		law(16'sh0000, 16'sh09c4);
		`CHK(aout, 16'sh09c4)
		wr(`PCO_SPLIT_A_IN, 32'h177007d0);
		man(16'sh0fa0, 16'sh0fa0);
		apb(1'b0, `PCO_OUTS, 32'h0);
		`CHK(r[15:0], 16'h1388)
		man(16'sh1f40, 16'sh1f40);
		apb(1'b0, `PCO_OUTS, 32'h0);
		`CHK(r[15:0], 16'h2710)
		wr(`PCO_SPLIT_A_IN, 32'h27100000);
	endtask

	task automatic t_pulse();
		int a;
		int b;
		setc(PCO_AO_A, PCO_TWO_PT, 6'b000010);
		man(16'sh0fa0, 16'sh0fa0);
		pulses(a, b);
		`CHK(a, 32'h28)
		`CHK(b, 32'h0)
		setc(PCO_AO_A, PCO_THREE, 6'b000010);
		pulses(a, b);
		`CHK(a, 32'h28)
		`CHK(b, 32'h3c)
	endtask

	task automatic wait_chk(input logic up);
		n = 0;
		while ((up ? up_chk : lo_chk) !== 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 1000) stuck();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic t_step();
		wr(`PCO_SPLIT_B_OUT, 32'h27100000);
		setc(PCO_AO_A, PCO_STEP, 6'b000010);
		man(16'sh1b58, 16'sh1b58);
		`CHK(pins.raise, 1'b1)
		`CHK(pins.lower, 1'b0)
		wait_chk(1'b1);
		`CHK(pins.raise, 1'b0)
		man(16'sh1388, 16'sh1388);
		repeat (20) @(posedge clk);
		#1;
		`CHK({pins.raise, pins.lower}, 2'b00)
		man(16'sh0bb8, 16'sh0bb8);
		`CHK(pins.lower, 1'b1)
		wait_chk(1'b0);
		`CHK(pins.lower, 1'b0)
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_period();
		t_law();
		t_auto_op();
		t_select();
		t_split();
		t_pulse();
		t_step();
		tally_and_finish();
	end
endmodule

// ---- rtl/pco_core.sv ----
// control law, output limiting, split range and pulse/step output stage
`include "pco_regs.svh"

module pco_core
	import pco_pkg::*;
#(
	parameter int unsigned SAMPLE_RST = `PCO_SAMPLE_RST
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// process side
	input  wire pco_val_t    control_deviation_i,
	input  wire pco_val_t    tracking_i,
	input  wire pco_val_t    analog_in_i,
	input  wire logic        track_di_i,
	input  wire logic        safety_di_i,
	input  wire logic        upper_chk_i,
	input  wire logic        lower_chk_i,
	// actuator side
	output pco_val_t         limited_manipulated_value_o,
	output pco_val_t         analog_out_o,
	output pco_pins_t        pins_o,
	output logic             sample_o
);

	// refuse a default period that the tick counter cannot serve
	if (SAMPLE_RST < 2) begin : g_bad_sample
		$error("sampling period must be two cycles or more");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	pco_ctrl_t   ctrl;
	logic [31:0] sample_per;
	pco_val_t    gain;
	logic [15:0] ki;
	logic [15:0] kd;
	logic [15:0] lag;
	pco_val_t    deadband;
	pco_pair_t   lim;
	pco_val_t    op_cfg;
	pco_val_t    manual;
	pco_val_t    safety;
	pco_pair_t   sa_in;
	pco_pair_t   sa_out;
	pco_pair_t   sb_in;
	pco_pair_t   sb_out;
	logic [31:0] pulse_per;

	logic        wr_en;
	logic        rd_setup;
	logic        hit;

	assign wr_en    = psel_i && penable_i && pwrite_i;
	assign rd_setup = psel_i && !penable_i;
	assign pready_o = 1'b1;

	always_comb begin
		case (paddr_i)
			`PCO_CTRL, `PCO_SAMPLE, `PCO_GAIN, `PCO_KI, `PCO_KD, `PCO_LAG,
			`PCO_DEADBAND, `PCO_LIMITS, `PCO_OP_POINT, `PCO_MANUAL,
			`PCO_SAFETY, `PCO_SPLIT_A_IN, `PCO_SPLIT_A_OUT, `PCO_SPLIT_B_IN,
			`PCO_SPLIT_B_OUT, `PCO_PULSE, `PCO_STATUS, `PCO_OUTS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	assign pslverr_o = psel_i && penable_i && !hit;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl       <= '0;
			sample_per <= 32'h0;
			gain       <= `PCO_GAIN_RST;
			ki         <= 16'h0;
			kd         <= 16'h0;
			lag        <= 16'h0;
			deadband   <= 16'sh0;
			lim        <= `PCO_LIM_RST;
			op_cfg     <= 16'sh0;
			manual     <= 16'sh0;
			safety     <= 16'sh0;
			sa_in      <= `PCO_SPLIT_RST;
			sa_out     <= `PCO_SPLIT_RST;
			sb_in      <= `PCO_SPLIT_RST;
			sb_out     <= `PCO_SPLIT_RST;
			pulse_per  <= `PCO_PULSE_RST;
		end else if (wr_en) begin
			case (paddr_i)
				`PCO_CTRL:        ctrl <= pco_ctrl_t'(pwdata_i[`PCO_CTRL_W-1:0]);
				`PCO_SAMPLE:      sample_per <= pwdata_i;
				`PCO_GAIN:        gain <= pwdata_i[15:0];
				`PCO_KI:          ki <= pwdata_i[15:0];
				`PCO_KD:          kd <= pwdata_i[15:0];
				`PCO_LAG:         lag <= pwdata_i[15:0];
				`PCO_DEADBAND:    deadband <= pwdata_i[15:0];
				`PCO_LIMITS:      lim <= pwdata_i;
				`PCO_OP_POINT:    op_cfg <= pwdata_i[15:0];
				`PCO_MANUAL:      manual <= pwdata_i[15:0];
				`PCO_SAFETY:      safety <= pwdata_i[15:0];
				`PCO_SPLIT_A_IN:  sa_in <= pwdata_i;
				`PCO_SPLIT_A_OUT: sa_out <= pwdata_i;
				`PCO_SPLIT_B_IN:  sb_in <= pwdata_i;
				`PCO_SPLIT_B_OUT: sb_out <= pwdata_i;
				`PCO_PULSE:       pulse_per <= pwdata_i;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sampling period
	// ----------------------------------------------------------------
	logic [31:0] samp_cnt;
	logic [31:0] samp_len;
	logic        tick;

	assign samp_len = (sample_per < 32'd2) ? 32'(SAMPLE_RST) : sample_per;
	assign tick     = (samp_cnt >= samp_len - 32'd1);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			samp_cnt <= 32'h0;
		else
			samp_cnt <= tick ? 32'h0 : samp_cnt + 32'd1;
	end

	// ----------------------------------------------------------------
	// control law
	// ----------------------------------------------------------------
	logic signed [63:0] e_db;
	logic signed [63:0] ge;
	logic signed [63:0] ge_prev;
	logic signed [63:0] integ;
	logic signed [63:0] deriv;
	logic signed [63:0] op_eff;
	logic signed [63:0] inc;
	logic signed [63:0] next_integ;
	logic signed [63:0] next_deriv;
	logic signed [63:0] next_op;
	logic signed [63:0] u;
	logic signed [63:0] src;
	logic signed [63:0] dev;
	logic signed [63:0] db;
	pco_val_t           limited_manipulated_value;
	pco_val_t           next_lmn;
	logic               auto_prev;
	logic               at_hi;
	logic               at_lo;
	logic               to_auto;
	logic               track_on;
	logic               safe_on;
	logic               run_auto;

	assign at_hi    = (limited_manipulated_value >= lim.hi);
	assign at_lo    = (limited_manipulated_value <= lim.lo);
	assign track_on = ctrl.track_sel || track_di_i;
	assign safe_on  = ctrl.safety_sel || safety_di_i;
	assign run_auto = ctrl.auto_mode && !track_on && !safe_on;
	assign to_auto  = run_auto && !auto_prev;
	assign dev      = 64'(control_deviation_i);
	assign db       = 64'(deadband);

	always_comb begin
		// dead band with offset, no step at band edges
		if (dev > db)
			e_db = dev - db; // [R08]
		else if (dev < -db)
			e_db = dev + db; // [R08]
		else
			e_db = 64'sh0; // [R07]
		ge = (64'(gain) * e_db) >>> 8; // [R22]
		// trapezoid integral over the sample, frozen at a limit
		// signed coefficients keep the shifts arithmetic for negative terms
		inc = (64'(signed'({1'b0, ki})) * (ge + ge_prev)) >>> 17; // [R05]
		if (ctrl.pd_mode || ki == 16'h0)
			next_integ = 64'sh0; // [R01] [R21]
		else if ((at_hi && inc > 0) || (at_lo && inc < 0))
			next_integ = integ; // [R06]
		else
			next_integ = integ + inc; // [R05]
		// lagged trapezoid derivative
		if (kd == 16'h0)
			next_deriv = 64'sh0; // [R21]
		else
			next_deriv = ((64'(signed'({1'b0, lag})) * deriv) >>> 16)
				+ ((64'(signed'({1'b0, kd})) * (ge - ge_prev))
				>>> 8); // [R03] [R04]
		next_op = op_eff;
		if (!ctrl.pd_mode)
			next_op = 64'(op_cfg);
		else if (!ctrl.auto_op)
			next_op = 64'(op_cfg); // [R12]
		else if (to_auto)
			next_op = ctrl.bumpless ? 64'(limited_manipulated_value) - ge - next_deriv
				: 64'(limited_manipulated_value); // [R02] [R11]
		// with bumpless set, integrator tracks the output while not in automatic
		if (!run_auto && !ctrl.pd_mode && ki != 16'h0 && ctrl.bumpless)
			next_integ = 64'(limited_manipulated_value) - ge - next_deriv - next_op; // [R11]
		u = ge + next_integ + next_deriv + next_op; // [R05]
		if (safe_on)
			src = 64'(safety); // [R09]
		else if (track_on)
			src = 64'(tracking_i); // [R09]
		else if (!ctrl.auto_mode)
			src = 64'(manual);
		else
			src = u;
		if (src > 64'(lim.hi))
			next_lmn = lim.hi; // [R10]
		else if (src < 64'(lim.lo))
			next_lmn = lim.lo; // [R10]
		else
			next_lmn = pco_val_t'(src[15:0]);
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ge_prev   <= 64'sh0;
			integ     <= 64'sh0;
			deriv     <= 64'sh0;
			op_eff    <= 64'sh0;
			limited_manipulated_value       <= 16'sh0;
			auto_prev <= 1'b0;
		end else if (tick) begin
			ge_prev   <= ge; // [R23]
			integ     <= next_integ;
			deriv     <= next_deriv;
			op_eff    <= next_op;
			limited_manipulated_value       <= next_lmn;
			auto_prev <= run_auto;
		end
	end

	// ----------------------------------------------------------------
	// split range and analog output
	// ----------------------------------------------------------------
	function automatic pco_val_t split(input pco_val_t x, input pco_pair_t
		in_r, input pco_pair_t out_r);
		logic signed [63:0] num;
		num = 64'sh0;
		if (x <= in_r.lo || in_r.hi <= in_r.lo)
			split = out_r.lo; // [R24]
		else if (x >= in_r.hi)
			split = out_r.hi; // [R24]
		else begin
			num   = (64'(x) - 64'(in_r.lo)) * (64'(out_r.hi) - 64'(out_r.lo))
				/ (64'(in_r.hi) - 64'(in_r.lo)); // [R14]
			split = pco_val_t'(num[15:0] + out_r.lo);
		end
	endfunction

	pco_val_t val_a;
	pco_val_t val_b;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			val_a        <= 16'sh0;
			val_b        <= 16'sh0;
			analog_out_o <= 16'sh0;
		end else if (tick) begin
			val_a <= split(next_lmn, sa_in, sa_out); // [R13]
			val_b <= split(next_lmn, sb_in, sb_out); // [R13]
			case (ctrl.ao_src)
				PCO_AO_A:  analog_out_o <= split(next_lmn, sa_in, sa_out); // [R15]
				PCO_AO_B:  analog_out_o <= split(next_lmn, sb_in, sb_out); // [R15]
				PCO_AO_IN: analog_out_o <= analog_in_i; // [R15]
				default:   analog_out_o <= 16'sh0;
			endcase
		end
	end

	assign limited_manipulated_value_o = limited_manipulated_value;

	// ----------------------------------------------------------------
	// pulse shaper and step outputs
	// ----------------------------------------------------------------
	logic [31:0] pwm_cnt;
	logic [31:0] on_a;
	logic [31:0] on_b;
	logic [31:0] pwm_len;

	function automatic logic [31:0] duty(input pco_val_t v,
		input logic [31:0] per);
		logic [63:0] t;
		t = 64'h0;
		if (v <= 0)
			duty = 32'h0;
		else if (v >= `PCO_FULL_SCALE)
			duty = per;
		else begin
			t    = (64'(per) * 64'(v)) / 64'(`PCO_FULL_SCALE);
			duty = t[31:0];
		end
	endfunction

	assign pwm_len = (pulse_per == 32'h0) ? 32'd1 : pulse_per;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_cnt <= 32'h0;
			on_a    <= 32'h0;
			on_b    <= 32'h0;
		end else begin
			if (pwm_cnt >= pwm_len - 32'd1) begin
				pwm_cnt <= 32'h0;
				on_a    <= duty(val_a, pwm_len); // [R16]
				on_b    <= duty(val_b, pwm_len); // [R17]
			end else
				pwm_cnt <= pwm_cnt + 32'd1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pins_o <= '0;
		else begin
			pins_o.pulse_a <= (ctrl.mode == PCO_TWO_PT
				|| ctrl.mode == PCO_THREE) && (pwm_cnt < on_a); // [R16]
			pins_o.pulse_b <= (ctrl.mode == PCO_THREE)
				&& (pwm_cnt < on_b); // [R17]
			pins_o.raise <= (ctrl.mode == PCO_STEP) && !upper_chk_i
				&& (limited_manipulated_value > `PCO_STEP_HI); // [R18] [R19]
			pins_o.lower <= (ctrl.mode == PCO_STEP) && !lower_chk_i
				&& (limited_manipulated_value < `PCO_STEP_LO); // [R18] [R20]
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sample_o <= 1'b0;
		else
			sample_o <= tick;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			prdata_o <= 32'h0;
		else if (rd_setup) begin
			case (paddr_i)
				`PCO_CTRL:        prdata_o <= 32'(ctrl);
				`PCO_SAMPLE:      prdata_o <= sample_per;
				`PCO_GAIN:        prdata_o <= {16'h0, gain};
				`PCO_KI:          prdata_o <= {16'h0, ki};
				`PCO_KD:          prdata_o <= {16'h0, kd};
				`PCO_LAG:         prdata_o <= {16'h0, lag};
				`PCO_DEADBAND:    prdata_o <= {16'h0, deadband};
				`PCO_LIMITS:      prdata_o <= lim;
				`PCO_OP_POINT:    prdata_o <= {16'h0, op_cfg};
				`PCO_MANUAL:      prdata_o <= {16'h0, manual};
				`PCO_SAFETY:      prdata_o <= {16'h0, safety};
				`PCO_SPLIT_A_IN:  prdata_o <= sa_in;
				`PCO_SPLIT_A_OUT: prdata_o <= sa_out;
				`PCO_SPLIT_B_IN:  prdata_o <= sb_in;
				`PCO_SPLIT_B_OUT: prdata_o <= sb_out;
				`PCO_PULSE:       prdata_o <= pulse_per;
				`PCO_STATUS:      prdata_o <= {8'h0, at_hi, at_lo, run_auto,
					1'b0, pins_o, limited_manipulated_value};
				`PCO_OUTS:        prdata_o <= {val_b, val_a};
				default:          prdata_o <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_tick_auto_pd;
		tick && ctrl.pd_mode;
	endsequence

	sequence s_one_step;
		##1 1'b1;
	endsequence

	a_pd_no_integral: assert property ( // [R01]
		s_tick_auto_pd |-> s_one_step ##0 (integ == 0))
		else $error("integral not cleared in pd mode");

	a_dead_band_zero: assert property ( // [R07]
		(dev <= db && dev >= -db) |-> e_db == 0)
		else $error("dead band output not zero");

	a_dead_band_slope: assert property ( // [R08]
		(dev > db) |-> e_db == dev - db)
		else $error("dead band slope wrong");

	a_limit_clamp: assert property ( // [R10]
		(tick && lim.hi >= lim.lo) |=> (limited_manipulated_value <= $past(lim.hi))
			&& (limited_manipulated_value >= $past(lim.lo)))
		else $error("manipulated value outside limits");

	a_once_per_sample: assert property ( // [R23]
		!tick |=> $stable(limited_manipulated_value) && $stable(integ))
		else $error("state changed outside a sample tick");

	a_integ_freeze: assert property ( // [R06]
		(tick && run_auto && at_hi && inc > 0 && !ctrl.pd_mode)
		|=> integ == $past(integ))
		else $error("integrator ran on at the limit");

	a_step_dead_mid: assert property ( // [R18]
		(limited_manipulated_value >= `PCO_STEP_LO && limited_manipulated_value <= `PCO_STEP_HI) [*2]
		|-> !pins_o.raise && !pins_o.lower)
		else $error("motor output active in mid band");

	a_raise_stop: assert property ( // [R19]
		upper_chk_i |=> !pins_o.raise)
		else $error("raise kept after upper checkback");

	a_lower_stop: assert property ( // [R20]
		lower_chk_i |=> !pins_o.lower)
		else $error("lower kept after lower checkback");

	a_b_only_three: assert property ( // [R17]
		(ctrl.mode != PCO_THREE) |=> !pins_o.pulse_b)
		else $error("output b pulsed outside three-point mode");

	a_ao_follows_in: assert property ( // [R15]
		(tick && ctrl.ao_src == PCO_AO_IN) |=> analog_out_o == $past(analog_in_i))
		else $error("analog output not following input");

	a_safety_wins: assert property ( // [R09]
		(tick && safe_on && safety <= lim.hi && safety >= lim.lo)
		|=> limited_manipulated_value == $past(safety))
		else $error("safety value not applied");

endmodule

// ---- rtl/pco_pkg.sv ----
// types of the control output stage
package pco_pkg;

	typedef logic signed [15:0] pco_val_t;

	// output stage modes, gray along analog, two-point, three-point, step
	typedef enum logic [1:0] {
		PCO_ANALOG = 2'b00,
		PCO_TWO_PT = 2'b01,
		PCO_THREE  = 2'b11,
		PCO_STEP   = 2'b10
	} pco_mode_t;

	typedef enum logic [1:0] {
		PCO_AO_A    = 2'b00,
		PCO_AO_B    = 2'b01,
		PCO_AO_IN   = 2'b11,
		PCO_AO_ZERO = 2'b10
	} pco_ao_t;

	typedef struct packed {
		pco_ao_t   ao_src;
		pco_mode_t mode;
		logic      safety_sel;
		logic      track_sel;
		logic      bumpless;
		logic      auto_op;
		logic      pd_mode;
		logic      auto_mode;
	} pco_ctrl_t;

	typedef struct packed {
		pco_val_t hi;
		pco_val_t lo;
	} pco_pair_t;

	typedef struct packed {
		logic     raise;
		logic     lower;
		logic     pulse_a;
		logic     pulse_b;
	} pco_pins_t;

endpackage

// ---- rtl/pco_regs.svh ----
// register map, field positions and fixed figures of the control output stage
// How it works
// R01: pd mode switches the integral off; zero deviation gives zero output; the code gives the operating point instead.
// R02: auto operating point takes the manual value at manual-to-auto change.
// R03: derivative of deviation by trapezoid rule, scaled by derivative action time.
// R04: derivative path has a first-order lag set by derivative lag time.
// R05: pid mode sums proportional, integral and derivative terms, both trapezoidal.
// R06: at an output limit the integrator holds its value.
// R07: deviation inside the dead band becomes zero.
// R08: outside the band output follows input, offset by the band width.
// R09: output selects computed value, tracking input or safety value.
// R10: manipulated value is always clamped between upper and lower limit; with the upper limit set below the lower, the code gives one of the two limits.
// R11: manual-to-auto change keeps the manipulated value without a step.
// R12: no correction for pure proportional with fixed operating point.
// R13: split range gives scaled values a and b from the limited value.
// R14: software keeps each split input start below its input end.
// R15: analog output drives value a, value b or analog input.
// R16: two-point mode pulses output a with duty equal to value a.
// R17: three-point mode also pulses output b with duty equal to value b.
// R18: step mode: value between 40.0% and 60.0% keeps both motor outputs off.
// R19: step mode: above 60.0% raise until upper limit checkback.
// R20: step mode: below 40.0% lower until lower limit checkback.
// R21: zero reset time or derivative time disables that term.
// R22: negative gain reverses the control action.
// R23: the whole law and outputs update once per sampling period; the code registers pins_o, the pulse and step outputs, every clock.
// R24: split output maps input interval linearly, holding end values outside.
`ifndef PCO_REGS_SVH
`define PCO_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCO_CTRL        8'h00
`define PCO_SAMPLE      8'h04
`define PCO_GAIN        8'h08
`define PCO_KI          8'h0c
`define PCO_KD          8'h10
`define PCO_LAG         8'h14
`define PCO_DEADBAND    8'h18
`define PCO_LIMITS      8'h1c
`define PCO_OP_POINT    8'h20
`define PCO_MANUAL      8'h24
`define PCO_SAFETY      8'h28
`define PCO_SPLIT_A_IN  8'h2c
`define PCO_SPLIT_A_OUT 8'h30
`define PCO_SPLIT_B_IN  8'h34
`define PCO_SPLIT_B_OUT 8'h38
`define PCO_PULSE       8'h3c
`define PCO_STATUS      8'h40
`define PCO_OUTS        8'h44

// ----------------------------------------------------------------
// fixed figures; values are signed, 0.01 % per lsb
// ----------------------------------------------------------------
`define PCO_FULL_SCALE  16'sh2710
`define PCO_STEP_LO     16'sh0fa0
`define PCO_STEP_HI     16'sh1770
`define PCO_CTRL_W      10
`define PCO_SAMPLE_RST  32'h000f4240
`define PCO_PULSE_RST   32'h05f5e100
`define PCO_GAIN_RST    16'h0100
`define PCO_LIM_RST     32'h27100000
`define PCO_SPLIT_RST   32'h27100000

`endif
